// file: include/wfd_pkg.sv
// Package: constants for the wake-frame detector
package wfd_pkg;
  // ----------------------------------------
  // Register map (wake registers in MMD device 31; interrupt register two at any device)
  // ----------------------------------------
  localparam logic [15:0] REG_INT_STATUS_TWO = 16'h0013;
  localparam logic [15:0] REG_WAKE_RX_CONFIG = 16'h04A0;
  localparam logic [15:0] REG_WAKE_RX_STATUS = 16'h04A1;
  localparam logic [4:0] MMD_DEVICE_VENDOR = 5'h1F;
  localparam logic [15:0] WAKE_CONFIG_RESET = 16'h0000;
  localparam logic [15:0] INT_TWO_RESET = 16'h0000;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CFG_ENABLE_BIT = 0;
  localparam int CFG_BCAST_BIT = 1;
  localparam int CFG_PWD_BIT = 2;
  localparam int CFG_PIN_LEVEL_BIT = 3;
  localparam int CFG_PIN_EN_BIT = 4;
  localparam int CFG_STAT_CLEAR_BIT = 5;
  localparam int STS_WAKE_BIT = 0;
  localparam int STS_BCAST_BIT = 1;
  localparam int STS_CRC_DROP_BIT = 2;
  localparam int INT2_WAKE_STATUS_BIT = 8;
  localparam int INT2_WAKE_ENABLE_BIT = 0;
  // ----------------------------------------
  // Sequence figures
  // ----------------------------------------
  localparam int SYNC_BYTES = 6;
  localparam logic [7:0] SYNC_VALUE = 8'hFF;
  localparam int ADDR_COPIES = 16;
  localparam int ADDR_BYTES = 6;
  localparam int PWD_BYTES = 6;
  localparam int DEST_BYTES = 6;
  localparam int PULSE_CYCLES = 8;
  typedef enum logic [2:0] {
    WFD_IDLE = 3'b000,
    WFD_SYNC = 3'b001,
    WFD_ADDR = 3'b011,
    WFD_PWD = 3'b010,
    WFD_DONE = 3'b110
  } wfd_state_t;
endpackage

// file: hw/wfd_wake_frame_detector.sv
// Wake-frame detector: byte scanner, CRC gate, register file and wake pin
module wfd_wake_frame_detector #(
  parameter int PULSE_LEN = wfd_pkg::PULSE_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic [47:0] stationAddr,
  input wire logic [47:0] wakePassword,
  input wire logic rxValid,
  input wire logic [7:0] rxByte,
  input wire logic rxStart,
  input wire logic rxEnd,
  input wire logic rxCrcOk,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [4:0] regDevice,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWdata,
  output logic [15:0] regRdata,
  output logic wakePin,
  output logic wakeIrq
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] cfg_q;
  logic intEn_q;
  logic intSts_q;
  logic stsWake_q;
  logic stsBcast_q;
  logic stsDrop_q;
  logic matchSeen_q;
  logic matchBcast_q;
  logic [2:0] destIdx_q;
  logic destOwn_q;
  logic destBcast_q;
  wfd_pkg::wfd_state_t state_q;
  logic [2:0] byteIdx_q;
  logic [3:0] copyIdx_q;
  logic frameEvent;
  logic wakeEvent;
  logic candidate;
  logic [7:0] addrByte;
  logic [7:0] pwdByte;
  logic [7:0] destByte;
  logic cfgWr;
  logic int2Rd;
  logic [7:0] pulseCnt_q;

  // Address bytes go out most significant first, as on the wire
  assign addrByte = stationAddr[8'(47 - 8 * byteIdx_q) -: 8];
  assign pwdByte = wakePassword[8'(47 - 8 * byteIdx_q) -: 8];
  assign destByte = stationAddr[8'(47 - 8 * destIdx_q) -: 8];
  // Only the vendor device reaches the wake registers; interrupt register two answers any device number
  assign cfgWr = regWrite && regDevice == wfd_pkg::MMD_DEVICE_VENDOR;
  assign int2Rd = regRead && regAddr == wfd_pkg::REG_INT_STATUS_TWO;
  assign candidate = cfg_q[wfd_pkg::CFG_ENABLE_BIT] &&
                     (destOwn_q || (destBcast_q && cfg_q[wfd_pkg::CFG_BCAST_BIT]));

  // ----------------------------------------
  // Destination address check
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      destIdx_q <= 3'h0;
      destOwn_q <= 1'b0;
      destBcast_q <= 1'b0;
    end else if (clkEn) begin
      if (rxStart) begin
        destIdx_q <= 3'h0;
        destOwn_q <= 1'b1;
        destBcast_q <= 1'b1;
      end else if (rxValid && destIdx_q < 3'(wfd_pkg::DEST_BYTES)) begin
        destIdx_q <= destIdx_q + 3'h1;
        if (rxByte != destByte) destOwn_q <= 1'b0;
        if (rxByte != 8'hFF) destBcast_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Sequence scanner
  // ----------------------------------------
  // Works on received bytes only, so line speed just changes byte spacing
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= wfd_pkg::WFD_IDLE;
      byteIdx_q <= 3'h0;
      copyIdx_q <= 4'h0;
      matchSeen_q <= 1'b0;
    end else if (clkEn) begin
      if (rxStart) begin
        state_q <= wfd_pkg::WFD_SYNC;
        byteIdx_q <= 3'h0;
        copyIdx_q <= 4'h0;
        matchSeen_q <= 1'b0;
      end else if (rxValid && state_q != wfd_pkg::WFD_IDLE) begin
        case (state_q)
          wfd_pkg::WFD_SYNC: begin
            if (rxByte == wfd_pkg::SYNC_VALUE) begin
              if (byteIdx_q == 3'(wfd_pkg::SYNC_BYTES - 1)) begin
                state_q <= wfd_pkg::WFD_ADDR;
                byteIdx_q <= 3'h0;
                copyIdx_q <= 4'h0;
              end else begin
                byteIdx_q <= byteIdx_q + 3'h1;
              end
            end else begin
              byteIdx_q <= 3'h0;
            end
          end
          wfd_pkg::WFD_ADDR: begin
            if (rxByte == addrByte) begin
              if (byteIdx_q == 3'(wfd_pkg::ADDR_BYTES - 1)) begin
                byteIdx_q <= 3'h0;
                if (copyIdx_q == 4'(wfd_pkg::ADDR_COPIES - 1)) begin
                  if (cfg_q[wfd_pkg::CFG_PWD_BIT]) begin
                    state_q <= wfd_pkg::WFD_PWD;
                  end else begin
                    state_q <= wfd_pkg::WFD_DONE;
                    matchSeen_q <= 1'b1;
                  end
                end else begin
                  copyIdx_q <= copyIdx_q + 4'h1;
                end
              end else begin
                byteIdx_q <= byteIdx_q + 3'h1;
              end
            end else if (rxByte == wfd_pkg::SYNC_VALUE && copyIdx_q == 4'h0 &&
                         byteIdx_q == 3'h0) begin
              // A seventh 0xFF keeps the sync run alive
              byteIdx_q <= 3'h0;
            end else begin
              // Restart on this byte; an 0xFF counts as first sync byte
              state_q <= wfd_pkg::WFD_SYNC;
              byteIdx_q <= (rxByte == wfd_pkg::SYNC_VALUE) ? 3'h1 : 3'h0;
            end
          end
          wfd_pkg::WFD_PWD: begin
            if (rxByte == pwdByte) begin
              if (byteIdx_q == 3'(wfd_pkg::PWD_BYTES - 1)) begin
                state_q <= wfd_pkg::WFD_DONE;
                matchSeen_q <= 1'b1;
              end else begin
                byteIdx_q <= byteIdx_q + 3'h1;
              end
            end else begin
              state_q <= wfd_pkg::WFD_SYNC;
              byteIdx_q <= (rxByte == wfd_pkg::SYNC_VALUE) ? 3'h1 : 3'h0;
            end
          end
          wfd_pkg::WFD_DONE: begin
            state_q <= wfd_pkg::WFD_DONE;
          end
          default: begin
            state_q <= wfd_pkg::WFD_IDLE;
          end
        endcase
      end
    end
  end

  // Decision only at frame end, once CRC is known
  assign frameEvent = rxEnd && matchSeen_q && candidate;
  assign wakeEvent = frameEvent && rxCrcOk;

  // ----------------------------------------
  // Configuration and status registers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= wfd_pkg::WAKE_CONFIG_RESET;
      intEn_q <= 1'b0;
    end else if (clkEn) begin
      if (cfgWr && regAddr == wfd_pkg::REG_WAKE_RX_CONFIG) cfg_q <= regWdata;
      if (regWrite && regAddr == wfd_pkg::REG_INT_STATUS_TWO) begin
        intEn_q <= regWdata[wfd_pkg::INT2_WAKE_ENABLE_BIT];
      end
    end
  end

  // Status is sticky; an event in the clearing cycle still lands
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stsWake_q <= 1'b0;
      stsBcast_q <= 1'b0;
      stsDrop_q <= 1'b0;
    end else if (clkEn) begin
      if (cfgWr && regAddr == wfd_pkg::REG_WAKE_RX_CONFIG &&
          regWdata[wfd_pkg::CFG_STAT_CLEAR_BIT]) begin
        stsWake_q <= wakeEvent;
        stsBcast_q <= wakeEvent && !destOwn_q;
        stsDrop_q <= frameEvent && !rxCrcOk;
      end else begin
        if (wakeEvent) stsWake_q <= 1'b1;
        if (wakeEvent && !destOwn_q) stsBcast_q <= 1'b1;
        if (frameEvent && !rxCrcOk) stsDrop_q <= 1'b1;
      end
    end
  end

  // Interrupt flag clears on read of interrupt register two; set wins
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      intSts_q <= 1'b0;
      wakeIrq <= 1'b0;
    end else if (clkEn) begin
      if (wakeEvent) intSts_q <= 1'b1;
      else if (int2Rd) intSts_q <= 1'b0;
      wakeIrq <= (wakeEvent || (intSts_q && !int2Rd)) && intEn_q;
    end
  end

  // ----------------------------------------
  // Wake pin: pulse or level
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pulseCnt_q <= 8'h00;
      wakePin <= 1'b0;
    end else if (clkEn) begin
      if (!cfg_q[wfd_pkg::CFG_PIN_EN_BIT]) begin
        wakePin <= 1'b0;
        pulseCnt_q <= 8'h00;
      end else if (cfg_q[wfd_pkg::CFG_PIN_LEVEL_BIT]) begin
        // Level mode holds until software clears the wake status
        wakePin <= wakeEvent || stsWake_q;
      end else if (wakeEvent) begin
        pulseCnt_q <= 8'(PULSE_LEN - 1);
        wakePin <= 1'b1;
      end else if (pulseCnt_q != 8'h00) begin
        pulseCnt_q <= pulseCnt_q - 8'h01;
      end else begin
        wakePin <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= 16'h0000;
    end else if (clkEn && regRead) begin
      regRdata <= 16'h0000;
      if (regAddr == wfd_pkg::REG_INT_STATUS_TWO) begin
        regRdata[wfd_pkg::INT2_WAKE_STATUS_BIT] <= intSts_q;
        regRdata[wfd_pkg::INT2_WAKE_ENABLE_BIT] <= intEn_q;
      end else if (regDevice == wfd_pkg::MMD_DEVICE_VENDOR) begin
        if (regAddr == wfd_pkg::REG_WAKE_RX_CONFIG) regRdata <= cfg_q;
        if (regAddr == wfd_pkg::REG_WAKE_RX_STATUS) begin
          regRdata[wfd_pkg::STS_WAKE_BIT] <= stsWake_q;
          regRdata[wfd_pkg::STS_BCAST_BIT] <= stsBcast_q;
          regRdata[wfd_pkg::STS_CRC_DROP_BIT] <= stsDrop_q;
        end
      end
    end
  end
endmodule

// file: dv/wfd_chk.sv
// Port-level checker for the wake-frame detector
module wfd_chk (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic rxEnd,
  input wire logic rxCrcOk,
  input wire logic regRead,
  input wire logic [4:0] regDevice,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regRdata,
  input wire logic wakePin,
  input wire logic wakeIrq
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // Assertions
  // ----
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire rdTaken = regRead && clkEn;
  a_pin_after_crc: assert property ($rose(wakePin) |-> $past(rxEnd && rxCrcOk && clkEn))
    else $error("wake pin rose without a good frame end");
  a_irq_after_crc: assert property ($rose(wakeIrq) |-> $past(rxEnd && rxCrcOk && clkEn))
    else $error("wake irq rose without a good frame end");
  a_bad_crc_quiet: assert property (rxEnd && !rxCrcOk && clkEn |=> !$rose(wakePin) && !$rose(wakeIrq))
    else $error("wake raised for bad crc frame");
  a_frozen_outputs: assert property (!clkEn |=> $stable(wakePin) && $stable(wakeIrq))
    else $error("outputs moved while clock enable low");
  a_rdata_holds: assert property (!rdTaken |=> $stable(regRdata))
    else $error("read data moved without a read");
  a_wrong_device: assert property (rdTaken && regDevice != 5'h1F &&
    (regAddr == 16'h04A0 || regAddr == 16'h04A1) |=> regRdata == 16'h0000)
    else $error("extended read with wrong device not zero");
  // Read-to-clear drops the irq within one to three edges, even when the enable is low
  a_irq_read_clears: assert property (rdTaken && regAddr == 16'h0013 && !rxEnd |-> ##[1:3] !wakeIrq)
    else $error("wake irq not cleared by status read");
  a_reset_quiet: assert property (disable iff (1'b0) !rstn |-> !wakePin && !wakeIrq && regRdata == 16'h0000)
    else $error("outputs not quiet in reset");
  c_pin: cover property ($rose(wakePin));
  c_bad_crc: cover property (rxEnd && !rxCrcOk && clkEn);
  c_irq_clear: cover property ($fell(wakeIrq));
endmodule

// file: dv/wfd_rx_model.sv
// Receive datapath model that hands frame bytes to the detector
module wfd_rx_model (
  input wire logic mclk,
  input wire logic clkEn,
  output logic rxValid,
  output logic [7:0] rxByte,
  output logic rxStart,
  output logic rxEnd,
  output logic rxCrcOk
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    rxValid = 1'b0;
    rxByte = 8'h00;
    rxStart = 1'b0;
    rxEnd = 1'b0;
    rxCrcOk = 1'b0;
  end
  // A strobe stands until an edge with the enable high takes it
  task automatic take();
    @(posedge mclk);
    while (!clkEn) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic send(input logic [7:0] q[$], input logic crcGood);
    rxStart = 1'b1;
    take();
    rxStart = 1'b0;
    foreach (q[i]) begin
      rxValid = 1'b1;
      rxByte = q[i];
      take();
    end
    rxValid = 1'b0;
    // Idle lane shows the inverse so a stale byte cannot pass as data
    rxByte = ~rxByte;
    rxEnd = 1'b1;
    rxCrcOk = crcGood;
    take();
    rxEnd = 1'b0;
    rxCrcOk = ~crcGood;
  endtask
endmodule

// file: dv/tb.sv
// Testbench for the wake-frame detector
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, rstn, clkEn, slow, regWrite, regRead;
  logic rxValid, rxStart, rxEnd, rxCrcOk, wakePin, wakeIrq;
  logic [7:0] rxByte;
  logic [4:0] regDevice;
  logic [15:0] regAddr, regWdata, regRdata, cfg;
  logic [47:0] stationAddr = 48'h112233445566;
  logic [47:0] wakePassword = 48'h2A2B2C2D2E2F;
  logic [7:0] q[$];
  int fail_count, samples_checked, pinCycles, pinBase;
  wfd_wake_frame_detector #(.PULSE_LEN(2)) dut_u (.mclk, .rstn, .clkEn, .stationAddr,
    .wakePassword, .rxValid, .rxByte, .rxStart, .rxEnd, .rxCrcOk, .regWrite, .regRead,
    .regDevice, .regAddr, .regWdata, .regRdata, .wakePin, .wakeIrq);
  wfd_rx_model rx_u (.mclk, .clkEn, .rxValid, .rxByte, .rxStart, .rxEnd, .rxCrcOk);
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Slow mode halves the byte rate, standing in for the lower line speed
  always @(negedge mclk) clkEn <= slow ? ~clkEn : 1'b1;
  always @(posedge mclk) if (wakePin === 1'b1 && clkEn) pinCycles++;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic access(input logic wr, input logic [4:0] dev, input logic [15:0] a,
      input logic [15:0] d);
    @(negedge mclk);
    regWrite = wr;
    regRead = ~wr;
    regDevice = dev;
    regAddr = a;
    regWdata = d;
    rx_u.take();
    regWrite = 1'b0;
    regRead = 1'b0;
  endtask
  task automatic rd(input logic [4:0] dev, input logic [15:0] a, input logic [15:0] exp);
    access(1'b0, dev, a, 16'h0000);
    check(regRdata, exp);
  endtask
  task automatic frame(input logic [47:0] dest, input int nSync, input int nCopies,
      input logic pwd, input logic crc, input logic [15:0] exp);
    q = {};
    for (int i = 5; i >= 0; i--) q.push_back(dest[i*8 +: 8]);
    q = {q, 8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hFF, 8'h00, 8'h11};
    repeat (nSync) q.push_back(8'hFF);
    repeat (nCopies) for (int i = 5; i >= 0; i--) q.push_back(stationAddr[i*8 +: 8]);
    if (pwd) for (int i = 5; i >= 0; i--) q.push_back(wakePassword[i*8 +: 8]);
    q.push_back(8'h5A);
    pinBase = pinCycles;
    @(negedge mclk);
    rx_u.send(q, crc);
    repeat (20) @(negedge mclk);
    // Level mode keeps the pin up for all 20 cycles, pulse mode for two
    check(16'(pinCycles - pinBase),
      exp[0] ? (cfg[3] ? 16'h0014 : 16'h0002) : 16'h0000);
    check({15'h0000, wakeIrq}, {15'h0000, exp[0]});
    rd(5'h1F, 16'h04A1, exp);
    rd(5'h1F, 16'h0013, {7'h00, exp[0], 8'h01});
    repeat (3) @(negedge mclk);
    check({15'h0000, wakeIrq}, 16'h0000);
    access(1'b1, 5'h1F, 16'h04A0, cfg | 16'h0020);
    repeat (2) @(negedge mclk);
    check({15'h0000, wakePin}, 16'h0000);
  endtask
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #400000;
    fail_count++;
    print_verdict();
  end
  initial begin
    {rstn, slow, regWrite, regRead, regAddr, regWdata, cfg} = '0;
    regDevice = 5'h1F;
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    rstn = 1'b1;
    rd(5'h1F, wfd_pkg::REG_WAKE_RX_CONFIG, wfd_pkg::WAKE_CONFIG_RESET);
    rd(5'h1F, wfd_pkg::REG_WAKE_RX_STATUS, 16'h0000);
    rd(5'h1F, wfd_pkg::REG_INT_STATUS_TWO, wfd_pkg::INT_TWO_RESET);
    cfg = 16'h0013;
    access(1'b1, 5'h1F, 16'h04A0, cfg);
    access(1'b1, 5'h1F, 16'h0013, 16'h0001);
    access(1'b1, 5'h03, 16'h04A0, 16'hFFFF);
    rd(5'h1F, 16'h04A0, cfg);
    rd(5'h03, 16'h04A0, 16'h0000);
    rd(5'h1F, 16'h0020, 16'h0000);
    $display("test registers done");
    frame(stationAddr, 6, 16, 1'b0, 1'b1, 16'h0001);
    frame(stationAddr, 7, 16, 1'b0, 1'b1, 16'h0001);
    frame(stationAddr, 5, 16, 1'b0, 1'b1, 16'h0000);
    frame(stationAddr, 6, 15, 1'b0, 1'b1, 16'h0000);
    frame(stationAddr, 6, 16, 1'b0, 1'b0, 16'h0004);
    frame(48'hFFFFFFFFFFFF, 6, 16, 1'b0, 1'b1, 16'h0003);
    frame(48'h0A0B0C0D0E0F, 6, 16, 1'b0, 1'b1, 16'h0000);
    // Level mode on the pin, then detection switched off
    cfg = 16'h001B;
    access(1'b1, 5'h1F, 16'h04A0, cfg);
    frame(stationAddr, 6, 16, 1'b0, 1'b1, 16'h0001);
    cfg = 16'h0012;
    access(1'b1, 5'h1F, 16'h04A0, cfg);
    frame(stationAddr, 6, 16, 1'b0, 1'b1, 16'h0000);
    $display("test frames done");
    cfg = 16'h0017;
    access(1'b1, 5'h1F, 16'h04A0, cfg);
    frame(stationAddr, 6, 16, 1'b0, 1'b1, 16'h0000);
    frame(stationAddr, 6, 16, 1'b1, 1'b1, 16'h0001);
    slow = 1'b1;
    frame(stationAddr, 6, 16, 1'b1, 1'b1, 16'h0001);
    $display("test password and slow speed done");
    print_verdict();
  end
endmodule
bind wfd_wake_frame_detector wfd_chk chk_u (.mclk, .rstn, .clkEn, .rxEnd, .rxCrcOk,
  .regRead, .regDevice, .regAddr, .regRdata, .wakePin, .wakeIrq);
